// ===== common/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_SEQLEN 12'h004
`define ACS_OFF_RSEQ0 12'h008
`define ACS_OFF_RSEQ1 12'h00c
`define ACS_OFF_ISEQ 12'h010
`define ACS_OFF_STATUS 12'h014
`define ACS_OFF_MASK 12'h018
`define ACS_OFF_RRES 12'h01c
`define ACS_OFF_IRES1 12'h020
`define ACS_OFF_STATE 12'h024
`define ACS_CTRL_PWR 0
`define ACS_CTRL_SCAN 1
`define ACS_CTRL_REPEAT_ROUNDS_BIT 2
`define ACS_CTRL_RDISC 3
`define ACS_CTRL_IDISC 4
`define ACS_CTRL_AUTO 5
`define ACS_CTRL_REXT 6
`define ACS_CTRL_IEXT 7
`define ACS_CTRL_SHORT_LSB 8
`define ACS_ST_EOC 0
`define ACS_ST_INJECTED_DONE_FLAG 1
`define ACS_RESET_WORD 32'h0000_0000
`endif

// ===== common/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {ACS_GRP_REG, ACS_GRP_INJ} acs_grp_t;
  // Fields run from the top bit down, so the struct maps straight onto the control word.
  typedef struct packed {
    logic [2:0] short_run_length;
    logic injected_external_trigger_enable;
    logic reg_ext_en;
    logic auto_inject_bit;
    logic injected_short_run_enable;
    logic regular_short_run_enable;
    logic repeat_rounds_bit;
    logic scan;
    logic power_on;
  } acs_ctrl_t;
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic inj;
  } acs_req_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } acs_res_t;
endpackage

// ===== hw/acs_sequencer.sv
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_sequencer
  import acs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic reg_trig_i,
  input wire logic inj_trig_i,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic [3:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic [15:0] conv_data_i,
  output logic irq_o
);

  typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT} acs_state_t;
  acs_ctrl_t ctrl_reg;
  logic [3:0] rlen_reg;
  logic [1:0] ilen_reg;
  logic [63:0] rseq_reg;
  logic [15:0] iseq_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [15:0] rres_reg;
  logic [15:0] ires_reg;
  acs_state_t state_reg;
  logic grp_inj_reg;
  logic [3:0] rpos_reg;
  logic [1:0] ipos_reg;
  logic [3:0] run_cnt_reg;
  logic reg_pend_reg;
  logic inj_pend_reg;
  logic auto_pend_reg;
  logic pwr_d_reg;

  ////////////////////////////////////////////////////////////////////
  // Register bus slave.
  logic aw_full_reg;
  logic w_full_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [31:0] wmask;
  logic invalid_cfg;
  logic reg_start_ev;
  logic inj_start_ev;
  logic eoc_set;
  logic injected_done_flag_set;

  assign s_axi_awready_o = !aw_full_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_full_reg && !s_axi_bvalid_o;
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                  {8{w_strb_reg[0]}}};
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (aw_addr_reg > `ACS_OFF_STATE) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] acs_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [31:0] m);
    acs_merge = (old & ~m) | (nw & m);
  endfunction
  logic [31:0] ctrl_word;
  // The control struct is laid out bit for bit as the register word.
  assign ctrl_word = {21'h000000, ctrl_reg};
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= '0;
      rlen_reg <= 4'h0;
      ilen_reg <= 2'h0;
      rseq_reg <= 64'h0;
      iseq_reg <= 16'h0000;
      mask_reg <= 2'h0;
    end
    else if (wr_fire)
    begin
      unique case (aw_addr_reg)
        `ACS_OFF_CTRL: ctrl_reg <= acs_ctrl_t'(11'(acs_merge(ctrl_word, w_data_reg, wmask)));
        `ACS_OFF_SEQLEN:
        begin
          rlen_reg <= w_strb_reg[0] ? w_data_reg[3:0] : rlen_reg;
          ilen_reg <= w_strb_reg[1] ? w_data_reg[9:8] : ilen_reg;
        end
        `ACS_OFF_RSEQ0: rseq_reg[31:0] <= acs_merge(rseq_reg[31:0], w_data_reg, wmask);
        `ACS_OFF_RSEQ1: rseq_reg[63:32] <= acs_merge(rseq_reg[63:32], w_data_reg, wmask);
        `ACS_OFF_ISEQ: iseq_reg <= 16'(acs_merge({16'h0000, iseq_reg}, w_data_reg, wmask));
        `ACS_OFF_MASK: mask_reg <= w_strb_reg[0] ? w_data_reg[1:0] : mask_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= `ACS_RESET_WORD;
      s_axi_rresp_o <= 2'h0;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= 2'h0;
      unique case (s_axi_araddr_i)
        `ACS_OFF_CTRL: s_axi_rdata_o <= ctrl_word;
        `ACS_OFF_SEQLEN: s_axi_rdata_o <= {22'h0, ilen_reg, 4'h0, rlen_reg};
        `ACS_OFF_RSEQ0: s_axi_rdata_o <= rseq_reg[31:0];
        `ACS_OFF_RSEQ1: s_axi_rdata_o <= rseq_reg[63:32];
        `ACS_OFF_ISEQ: s_axi_rdata_o <= {16'h0000, iseq_reg};
        `ACS_OFF_STATUS: s_axi_rdata_o <= {30'h0, status_reg};
        `ACS_OFF_MASK: s_axi_rdata_o <= {30'h0, mask_reg};
        `ACS_OFF_RRES: s_axi_rdata_o <= {16'h0000, rres_reg};
        `ACS_OFF_IRES1: s_axi_rdata_o <= {16'h0000, ires_reg};
        `ACS_OFF_STATE: s_axi_rdata_o <= {24'h0, rpos_reg, ipos_reg, grp_inj_reg,
                                          state_reg != S_IDLE};
        default:
        begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= 2'h2;
        end
      endcase
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Start events.
  // A discontinuous setup mixed with scan or auto-injection is refused outright.
  assign invalid_cfg = (ctrl_reg.regular_short_run_enable || ctrl_reg.injected_short_run_enable)
                       && (ctrl_reg.scan || ctrl_reg.auto_inject_bit);
  // Rising power-on write starts regular only, and not with regular short runs on; injected from its trigger or auto-injection after a regular scan.
  assign reg_start_ev = !invalid_cfg && ((ctrl_reg.power_on && !pwr_d_reg &&
                        !ctrl_reg.regular_short_run_enable) ||
                        (ctrl_reg.reg_ext_en && reg_trig_i));
  assign inj_start_ev = !invalid_cfg && ctrl_reg.injected_external_trigger_enable &&
                        inj_trig_i;
  always_ff @(posedge clk_i)
    pwr_d_reg <= rst_n_i && ctrl_reg.power_on;
  ////////////////////////////////////////////////////////////////////
  // Sequencer.
  logic [3:0] rlast;
  logic [1:0] ilast;
  logic rlast_hit;
  logic ilast_hit;
  logic run_full;
  logic rdisc;
  logic idisc;
  assign rdisc = ctrl_reg.regular_short_run_enable;
  assign idisc = ctrl_reg.injected_short_run_enable;
  // Without scan or short runs, a group is only its first ranked channel.
  assign rlast = (ctrl_reg.scan || rdisc) ? rlen_reg : 4'h0;
  assign ilast = (ctrl_reg.scan || idisc) ? ilen_reg : 2'h0;
  assign rlast_hit = rpos_reg == rlast;
  assign ilast_hit = ipos_reg == ilast;
  // Field value n means n+1 conversions, so a run never exceeds eight.
  assign run_full = run_cnt_reg == {1'b0, ctrl_reg.short_run_length};
  assign eoc_set = (state_reg == S_WAIT) && conv_done_i;
  assign injected_done_flag_set = eoc_set && grp_inj_reg;
  assign conv_chan_o = grp_inj_reg ? iseq_reg[ipos_reg*4 +: 4] : rseq_reg[rpos_reg*4 +: 4];
  assign conv_start_o = state_reg == S_START;
  assign conv_abort_o = (state_reg == S_WAIT) && !grp_inj_reg && inj_pend_reg
                        && !conv_done_i && ctrl_reg.scan;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= S_IDLE;
      grp_inj_reg <= 1'b0;
      rpos_reg <= 4'h0;
      ipos_reg <= 2'h0;
      run_cnt_reg <= 4'h0;
      reg_pend_reg <= 1'b0;
      inj_pend_reg <= 1'b0;
      auto_pend_reg <= 1'b0;
    end
    else
    begin
      // Pending starts are latched; a busy group ignores its own restart.
      if (reg_start_ev && !(state_reg != S_IDLE && !grp_inj_reg))
        reg_pend_reg <= 1'b1;
      if (inj_start_ev && !(state_reg != S_IDLE && grp_inj_reg))
        inj_pend_reg <= 1'b1;
      if (!ctrl_reg.power_on)
      begin
        state_reg <= S_IDLE;
        reg_pend_reg <= 1'b0;
        inj_pend_reg <= 1'b0;
      end
      else
      begin
        unique case (state_reg)
          S_IDLE:
          begin
            // Injected takes precedence so a waiting regular start runs after it.
            if (inj_pend_reg || auto_pend_reg)
            begin
              grp_inj_reg <= 1'b1;
              inj_pend_reg <= 1'b0;
              auto_pend_reg <= 1'b0;
              run_cnt_reg <= 4'h0;
              state_reg <= S_START;
            end
            else if (reg_pend_reg)
            begin
              grp_inj_reg <= 1'b0;
              reg_pend_reg <= 1'b0;
              run_cnt_reg <= 4'h0;
              state_reg <= S_START;
            end
          end
          S_START: state_reg <= S_WAIT;
          S_WAIT:
          begin
            if (conv_abort_o)
            begin
              // The aborted regular channel keeps its position and reruns later.
              reg_pend_reg <= 1'b1;
              grp_inj_reg <= 1'b1;
              inj_pend_reg <= 1'b0;
              state_reg <= S_START;
            end
            else if (conv_done_i && grp_inj_reg)
            begin
              ipos_reg <= ilast_hit ? 2'h0 : ipos_reg + 2'h1;
              run_cnt_reg <= run_cnt_reg + 4'h1;
              if (ilast_hit || (idisc && run_full))
                state_reg <= S_IDLE;
              else
                state_reg <= S_START;
              if (ilast_hit && ctrl_reg.repeat_rounds_bit && !idisc)
                inj_pend_reg <= 1'b1;
            end
            else if (conv_done_i)
            begin
              rpos_reg <= rlast_hit ? 4'h0 : rpos_reg + 4'h1;
              run_cnt_reg <= run_cnt_reg + 4'h1;
              if (rlast_hit || (rdisc && run_full))
                state_reg <= S_IDLE;
              else
                state_reg <= S_START;
              if (rlast_hit && ctrl_reg.scan && ctrl_reg.auto_inject_bit)
                auto_pend_reg <= 1'b1;
              if (rlast_hit && ctrl_reg.repeat_rounds_bit && !rdisc)
                reg_pend_reg <= 1'b1;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Results, flags and interrupt.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rres_reg <= 16'h0000;
      ires_reg <= 16'h0000;
    end
    else if (eoc_set && grp_inj_reg)
      ires_reg <= conv_data_i;
    else if (eoc_set)
      rres_reg <= conv_data_i;
  end
  logic [1:0] st_clr;
  assign st_clr = (wr_fire && aw_addr_reg == `ACS_OFF_STATUS && w_strb_reg[0]) ?
                  w_data_reg[1:0] : 2'h0;
  // A set in the same cycle as a clear wins, so no completion is lost.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      status_reg <= 2'h0;
    else
      status_reg <= (status_reg & ~st_clr) | {injected_done_flag_set, eoc_set};
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_reg & mask_reg);
  end
endmodule

// ===== sim/acs_conv_model.sv
`timescale 1ns/1ps
module acs_conv_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic slow_i,
  output logic done_o,
  output logic [15:0] data_o
);
  int seed = 7009;
  int cnt_reg;
  logic busy_reg;
  // Between results the data bus toggles, so a stale word never looks like a result.
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    data_o <= rst_n_i ? ~data_o : 16'h0000;
    cnt_reg <= start_i ? (slow_i ? 8 : 0) : cnt_reg - 1;
    if (!rst_n_i) busy_reg <= 1'b0;
    else if (start_i) busy_reg <= 1'b1;
    else if (abort_i) busy_reg <= 1'b0;
    else if (busy_reg && cnt_reg == 0)
    begin
      busy_reg <= 1'b0;
      done_o <= 1'b1;
      data_o <= 16'($random(seed));
    end
  end
endmodule

// ===== sim/acs_sequencer_monitor.sv
`timescale 1ns/1ps
module acs_sequencer_monitor
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic inj_trig_i,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic [3:0] conv_chan_o,
  input wire logic conv_done_i,
  input wire logic irq_o
);
  logic busy_reg;
  logic [2:0] cause_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  // An abort ends the conversion in flight, so the channel is free to move after it.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i) busy_reg <= 1'b0;
    else if (conv_start_o) busy_reg <= 1'b1;
    else if (conv_done_i || conv_abort_o) busy_reg <= 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i) cause_reg <= 3'h0;
    else cause_reg <= {cause_reg[1:0], conv_done_i || s_axi_bvalid_o};
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_start_pulse; conv_start_o |=> !conv_start_o; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_gap; busy_reg && !conv_done_i && !conv_abort_o |-> !conv_start_o; endproperty
  a_start_gap: assert property (p_start_gap) else $error("start during a conversion");
  property p_chan_hold; busy_reg && !conv_start_o && !conv_abort_o |-> $stable(conv_chan_o); endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid conversion");
  property p_abort_cause;
    $rose(conv_abort_o) |-> busy_reg && ($past(inj_trig_i) || $past(inj_trig_i, 2));
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort without trigger");
  property p_irq_cause; $rose(irq_o) |-> |cause_reg; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  property p_wr_resp; s_wr_both |-> ##2 s_axi_bvalid_o; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp; s_rd_taken |=> s_axi_rvalid_o; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_ar_refused; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_ar_refused: assert property (p_ar_refused) else $error("read taken while pending");
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "acs_map.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module testbench
  import acs_pkg::*;
;
  logic clk_i = 1'b0, rst_n_i = 1'b0, slow = 1'b0, cur_inj = 1'b0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1, reg_trig_i = 1'b0, inj_trig_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic conv_start_o, conv_abort_o, conv_done_i, irq_o;
  logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rsq, isq, d;
  logic [3:0] s_axi_wstrb_i = 4'hf, conv_chan_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic [15:0] conv_data_i, rres_e, ires_e;
  logic [5:0] exp_q[$];
  logic [5:0] fb = 6'h20, e;
  int seed = 7009, err_total = 0, checked = 0;
  always #4 clk_i = ~clk_i;
  acs_sequencer i_acs_sequencer (.*);
  acs_conv_model i_acs_conv_model (.clk_i, .rst_n_i, .start_i(conv_start_o),
    .abort_i(conv_abort_o), .slow_i(slow), .done_o(conv_done_i), .data_o(conv_data_i));
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_i)
  begin
    if (rst_n_i && conv_start_o)
    begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : fb;
      cur_inj = e[4];
      `CHK({2'b00, conv_chan_o}, {e[5], 1'b0, e[3:0]})
    end
    if (rst_n_i && conv_done_i && cur_inj) ires_e = conv_data_i;
    if (rst_n_i && conv_done_i && !cur_inj) rres_e = conv_data_i;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    while (!(ad && wd))
    begin
      @(negedge clk_i);
      ad = ad | s_axi_awready_o;
      wd = wd | s_axi_wready_o;
      @(posedge clk_i);
      s_axi_awvalid_i <= !ad;
      s_axi_wvalid_i <= !wd;
    end
    do @(negedge clk_i); while (!s_axi_bvalid_o);
    r = s_axi_bresp_o;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a);
    logic t;
    t = 1'b0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    while (!t)
    begin
      @(negedge clk_i);
      t = s_axi_arready_o;
      @(posedge clk_i);
      s_axi_arvalid_i <= !t;
    end
    do @(negedge clk_i); while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] w);
    rd(a);
    `CHK(d, w)
  endtask
  task automatic ck_irq(input logic w);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(irq_o, w)
    @(posedge clk_i);
  endtask
  task automatic pulse(input logic inj);
    inj_trig_i <= inj;
    reg_trig_i <= !inj;
    @(posedge clk_i);
    inj_trig_i <= 1'b0;
    reg_trig_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic q(input logic inj, input int k);
    exp_q.push_back({1'b0, inj, inj ? isq[4*k+:4] : rsq[4*k+:4]});
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 600 && exp_q.size() > n; i++) @(posedge clk_i);
  endtask
  task automatic drain();
    wait_q(0);
    repeat (30) @(posedge clk_i);
    `CHK(exp_q.size(), 0)
  endtask
  // A fresh rising edge of the power bit is the software start, so clear it first.
  task automatic go(input logic [31:0] v);
    wr(`ACS_OFF_CTRL, 32'h0);
    wr(`ACS_OFF_CTRL, v);
  endtask
  task automatic final_report();
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    final_report();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rsq = $random(seed);
    isq = $random(seed) & 32'hffff;
    rc(`ACS_OFF_CTRL, `ACS_RESET_WORD);
    rc(`ACS_OFF_STATUS, 32'h0);
    rd(12'h030);
    `CHK(r, 2'h2)
    wr(12'h030, 32'hffff_ffff);
    `CHK(r, 2'h2)
    wr(`ACS_OFF_SEQLEN, 32'h0000_0102);
    rc(`ACS_OFF_SEQLEN, 32'h0000_0102);
    wr(`ACS_OFF_RSEQ0, rsq);
    wr(`ACS_OFF_ISEQ, isq);
    wr(`ACS_OFF_MASK, 32'h1);
    q(0, 0);
    go(32'h1);
    drain();
    rc(`ACS_OFF_RRES, {16'h0, rres_e});
    rc(`ACS_OFF_STATUS, 32'h1);
    ck_irq(1'b1);
    wr(`ACS_OFF_MASK, 32'h0);
    ck_irq(1'b0);
    wr(`ACS_OFF_MASK, 32'h1);
    ck_irq(1'b1);
    wr(`ACS_OFF_STATUS, 32'h1);
    ck_irq(1'b0);
    wr(`ACS_OFF_MASK, 32'h2);
    wr(`ACS_OFF_CTRL, 32'h81);
    q(1, 0);
    pulse(1'b1);
    drain();
    rc(`ACS_OFF_IRES1, {16'h0, ires_e});
    rc(`ACS_OFF_STATUS, 32'h3);
    ck_irq(1'b1);
    wr(`ACS_OFF_STATUS, 32'h3);
    slow <= 1'b1;
    for (int k = 0; k < 6; k++) q(k inside {2, 3}, (k < 2) ? k : (k < 4) ? k - 2 : k - 3);
    go(32'h83);
    wait_q(4);
    pulse(1'b1);
    drain();
    wr(`ACS_OFF_CTRL, 32'hc3);
    for (int k = 0; k < 5; k++) q(k < 2, (k < 2) ? k : k - 2);
    pulse(1'b1);
    wait_q(4);
    pulse(1'b0);
    drain();
    slow <= 1'b0;
    for (int k = 0; k < 5; k++) q(k > 2, (k < 3) ? k : k - 3);
    go(32'h23);
    drain();
    wr(`ACS_OFF_CTRL, 32'h149);
    q(0, 0);
    q(0, 1);
    pulse(1'b0);
    pulse(1'b0);
    drain();
    q(0, 2);
    pulse(1'b0);
    drain();
    q(0, 0);
    q(0, 1);
    pulse(1'b0);
    drain();
    wr(`ACS_OFF_CTRL, 32'h749);
    rc(`ACS_OFF_CTRL, 32'h0000_0749);
    q(0, 2);
    pulse(1'b0);
    drain();
    for (int k = 0; k < 3; k++) q(0, k);
    pulse(1'b0);
    drain();
    wr(`ACS_OFF_CTRL, 32'h14b);
    pulse(1'b0);
    drain();
    wr(`ACS_OFF_CTRL, 32'h169);
    pulse(1'b0);
    drain();
    fb = {2'b00, rsq[3:0]};
    q(0, 0);
    q(0, 0);
    go(32'h5);
    drain();
    wr(`ACS_OFF_CTRL, 32'h1);
    repeat (6) @(posedge clk_i);
    fb = 6'h20;
    drain();
    final_report();
  end
endmodule
bind acs_sequencer acs_sequencer_monitor i_mon (.clk_i, .rst_n_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .inj_trig_i, .conv_start_o, .conv_abort_o, .conv_chan_o,
  .conv_done_i, .irq_o);
